/* faml_link.sv */
// The address map and register access over APB were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "faml_consts.svh"
module faml_link
    import faml_pkg::*;
#(
    parameter int unsigned CLK_HZ = `FAML_CLK_HZ
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic txd,
    input wire logic line_rx_busy,
    output logic rx_flush,
    output logic instruction_output,
    output logic instruction_error_flag
);
    if (CLK_HZ / `FAML_BAUD_300 > 65535 || CLK_HZ / `FAML_BAUD_19200 < 2 || CLK_HZ < 1000)
    begin : g_clk_check
        $error("faml_link: CLK_HZ outside the range the bit counter serves");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Rate tables
    function automatic int unsigned bit_cycles(input logic [2:0] sel);
        int unsigned rate;
        rate = `FAML_BAUD_19200;
        unique case (sel)
            3'h0: rate = `FAML_BAUD_300;
            3'h1: rate = `FAML_BAUD_600;
            3'h2: rate = `FAML_BAUD_1200;
            3'h3: rate = `FAML_BAUD_2400;
            3'h4: rate = `FAML_BAUD_4800;
            3'h5: rate = `FAML_BAUD_9600;
            default: rate = `FAML_BAUD_19200;
        endcase
        return CLK_HZ / rate;
    endfunction

    function automatic int unsigned limit_cycles(input logic [2:0] sel);
        int unsigned ms;
        ms = `FAML_TO_19200_MS;
        unique case (sel)
            3'h0, 3'h1, 3'h2: ms = `FAML_TO_SLOW_MS;
            3'h3: ms = `FAML_TO_2400_MS;
            3'h4: ms = `FAML_TO_4800_MS;
            3'h5: ms = `FAML_TO_9600_MS;
            default: ms = `FAML_TO_19200_MS;
        endcase
        return ms * (CLK_HZ / 1000);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // APB register file
    logic wr_stb;
    logic mem_hit;
    logic mapped;
    logic [7:0] src_type_reg, src_type_next, dst_type_reg, dst_type_next;
    logic [15:0] src_addr_reg, src_addr_next, dst_addr_reg, dst_addr_next;
    logic [15:0] size_reg, size_next, term_set_reg, term_set_next;
    logic [2:0] baud_reg, baud_next;
    logic instr_reg, instr_next;
    logic [31:0] prdata_reg, prdata_next;
    faml_mem_if mem_bus ();

    faml_state_type state_reg, state_next;
    logic [15:0] tx_status_reg, tx_status_next;
    logic [7:0] term_reg, term_next;
    logic prst_reg, prst_next, ierr_reg, ierr_next;
    logic [1:0] nstat_reg, nstat_next;

    assign wr_stb = psel & penable & pwrite;
    assign mem_hit = paddr[`FAML_MEM_BASE_BIT] & (paddr[1:0] == 2'h0);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = prdata_reg;
    assign mem_bus.we = wr_stb & mem_hit;
    assign mem_bus.waddr = paddr[9:2];
    assign mem_bus.wdata = pwdata[15:0];

    always_comb
    begin
        mapped = 1'b1;
        prdata_next = prdata_reg;
        src_type_next = src_type_reg;
        src_addr_next = src_addr_reg;
        size_next = size_reg;
        dst_type_next = dst_type_reg;
        dst_addr_next = dst_addr_reg;
        term_set_next = term_set_reg;
        baud_next = baud_reg;
        instr_next = instr_reg;
        if (!mem_hit)
        begin
            unique case (paddr)
                `FAML_OFF_CTRL, `FAML_OFF_SRC_TYPE, `FAML_OFF_SRC_ADDR, `FAML_OFF_SIZE,
                `FAML_OFF_DST_TYPE, `FAML_OFF_DST_ADDR, `FAML_OFF_TX_STATUS,
                `FAML_OFF_TERM, `FAML_OFF_BAUD, `FAML_OFF_FLAGS: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
        // Read data is captured in the setup cycle so the access phase needs no wait
        if (psel & ~penable & ~pwrite)
        begin
            prdata_next = 32'h0000_0000;
            unique case (paddr)
                `FAML_OFF_CTRL: prdata_next = {30'h0, prst_reg, instr_reg};
                `FAML_OFF_SRC_TYPE: prdata_next = {24'h0, src_type_reg};
                `FAML_OFF_SRC_ADDR: prdata_next = {16'h0, src_addr_reg};
                `FAML_OFF_SIZE: prdata_next = {16'h0, size_reg};
                `FAML_OFF_DST_TYPE: prdata_next = {24'h0, dst_type_reg};
                `FAML_OFF_DST_ADDR: prdata_next = {16'h0, dst_addr_reg};
                `FAML_OFF_TX_STATUS: prdata_next = {16'h0, tx_status_reg};
                `FAML_OFF_TERM: prdata_next = {16'h0, term_set_reg};
                `FAML_OFF_BAUD: prdata_next = {29'h0, baud_reg};
                `FAML_OFF_FLAGS: prdata_next = {16'h0, term_reg, 2'h0, nstat_reg, 1'b0,
                                                state_reg != FAML_IDLE, ierr_reg, instruction_output};
                default: prdata_next = 32'h0000_0000;
            endcase
        end
        if (wr_stb)
        begin
            unique case (paddr)
                `FAML_OFF_CTRL: instr_next = pwdata[`FAML_CTRL_INSTR];
                `FAML_OFF_SRC_TYPE: src_type_next = pwdata[7:0];
                `FAML_OFF_SRC_ADDR: src_addr_next = pwdata[15:0];
                `FAML_OFF_SIZE: size_next = pwdata[15:0];
                `FAML_OFF_DST_TYPE: dst_type_next = pwdata[7:0];
                `FAML_OFF_DST_ADDR: dst_addr_next = pwdata[15:0];
                `FAML_OFF_TERM: term_set_next = pwdata[15:0];
                `FAML_OFF_BAUD: baud_next = pwdata[2:0];
                default: instr_next = instr_reg;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= 32'h0000_0000;
            src_type_reg <= 8'h00;
            src_addr_reg <= 16'h0000;
            size_reg <= 16'h0000;
            dst_type_reg <= 8'h00;
            dst_addr_reg <= 16'h0000;
            term_set_reg <= `FAML_TERM_RESET;
            baud_reg <= `FAML_BAUD_RESET;
            instr_reg <= 1'b0;
        end
        else
        begin
            prdata_reg <= prdata_next;
            src_type_reg <= src_type_next;
            src_addr_reg <= src_addr_next;
            size_reg <= size_next;
            dst_type_reg <= dst_type_next;
            dst_addr_reg <= dst_addr_next;
            term_set_reg <= term_set_next;
            baud_reg <= baud_next;
            instr_reg <= instr_next;
        end
    end

    faml_msg_mem #(.DEPTH(256), .WIDTH(16)) u_mem (.pclk(pclk), .port(mem_bus));

    ////////////////////////////////////////////////////////////////////////////
    // Send engine
    logic instr_prev_reg;
    logic [8:0] word_reg, word_next;
    logic pend_reg, pend_next;
    logic [9:0] len_reg, len_next, byte_reg, byte_next, shift_reg, shift_next;
    logic [3:0] bit_reg, bit_next;
    logic [15:0] baud_cnt_reg, baud_cnt_next;
    logic [31:0] to_cnt_reg, to_cnt_next;
    logic [1:0] rst_cnt_reg, rst_cnt_next;
    logic flush_reg, flush_next, txd_reg, txd_next;
    logic start, is_tx, is_rx, tx_bad, rx_bad, scan_lo, scan_hi, sending;
    logic [7:0] prev_word;
    logic [31:0] div, limit;

    assign start = instr_reg & ~instr_prev_reg;
    assign is_tx = dst_type_reg == `FAML_TYPE_PORT;
    assign is_rx = src_type_reg == `FAML_TYPE_PORT;
    assign tx_bad = dst_addr_reg != 16'h0000 || size_reg == 16'h0000 || size_reg > `FAML_MAX_WORDS;
    assign rx_bad = src_addr_reg != 16'h0000 || size_reg != `FAML_MAX_WORDS;
    assign prev_word = word_reg[7:0] - 8'h01;
    assign scan_lo = pend_reg & (mem_bus.rdata[7:0] == term_reg);
    assign scan_hi = pend_reg & (mem_bus.rdata[15:8] == term_reg);
    assign sending = state_reg inside {FAML_FETCH, FAML_LOAD, FAML_SHIFT};
    assign div = bit_cycles(baud_reg);
    assign limit = limit_cycles(baud_reg);
    assign mem_bus.raddr = src_addr_reg[7:0] + ((state_reg == FAML_SCAN) ? word_reg[7:0] : byte_reg[8:1]);
    assign txd = txd_reg;
    assign rx_flush = flush_reg;
    assign instruction_output = instr_reg;
    assign instruction_error_flag = ierr_reg;

    always_comb
    begin
        state_next = state_reg;
        tx_status_next = tx_status_reg;
        term_next = term_reg;
        prst_next = prst_reg;
        ierr_next = ierr_reg;
        nstat_next = nstat_reg;
        word_next = word_reg;
        pend_next = 1'b0;
        len_next = len_reg;
        byte_next = byte_reg;
        shift_next = shift_reg;
        bit_next = bit_reg;
        baud_cnt_next = baud_cnt_reg;
        to_cnt_next = sending ? to_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
        rst_cnt_next = 2'h0;
        flush_next = 1'b0;
        if (wr_stb && paddr == `FAML_OFF_FLAGS && pwdata[`FAML_FLAGS_IERR])
        begin
            ierr_next = 1'b0;
        end
        if (wr_stb && paddr == `FAML_OFF_CTRL && pwdata[`FAML_CTRL_PRST])
        begin
            prst_next = 1'b1;
        end
        unique case (state_reg)
            FAML_IDLE:
            begin
                if (start && is_tx)
                begin
                    nstat_next = `FAML_NSTAT_TX;
                    if (tx_bad)
                        ierr_next = 1'b1;
                    else if (prst_reg)
                        tx_status_next = `FAML_ST_RESET;
                    else if (line_rx_busy)
                        tx_status_next = `FAML_ST_BUSY;
                    else
                    begin
                        tx_status_next = `FAML_ST_SENDING;
                        word_next = 9'h000;
                        state_next = FAML_SCAN;
                    end
                end
                else if (start && is_rx)
                begin
                    nstat_next = `FAML_NSTAT_RX;
                    ierr_next = ierr_next | rx_bad;
                end
                else if (prst_reg && !line_rx_busy)
                begin
                    flush_next = 1'b1;
                    state_next = FAML_RESET;
                end
            end
            FAML_SCAN:
            begin
                // One word issued per cycle, checked the cycle after
                if (scan_lo || scan_hi)
                begin
                    len_next = {1'b0, prev_word, 1'b0} + (scan_lo ? 10'h001 : 10'h002);
                    byte_next = 10'h000;
                    state_next = FAML_FETCH;
                end
                else if ({7'h00, word_reg} >= size_reg)
                begin
                    tx_status_next = `FAML_ST_NOTERM;
                    state_next = FAML_IDLE;
                end
                else
                begin
                    word_next = word_reg + 9'h001;
                    pend_next = 1'b1;
                end
            end
            FAML_FETCH: state_next = FAML_LOAD;
            FAML_LOAD:
            begin
                shift_next = {1'b1, byte_reg[0] ? mem_bus.rdata[15:8] : mem_bus.rdata[7:0], 1'b0};
                bit_next = 4'h0;
                baud_cnt_next = 16'h0000;
                state_next = FAML_SHIFT;
            end
            FAML_SHIFT:
            begin
                if ({16'h0000, baud_cnt_reg} == div - 32'h0000_0001)
                begin
                    baud_cnt_next = 16'h0000;
                    if (bit_reg == 4'h9)
                    begin
                        byte_next = byte_reg + 10'h001;
                        if (byte_reg + 10'h001 == len_reg)
                        begin
                            tx_status_next = `FAML_ST_OK;
                            state_next = FAML_IDLE;
                        end
                        else
                            state_next = FAML_FETCH;
                    end
                    else
                    begin
                        shift_next = {1'b1, shift_reg[9:1]};
                        bit_next = bit_reg + 4'h1;
                    end
                end
                else
                    baud_cnt_next = baud_cnt_reg + 16'h0001;
            end
            FAML_RESET:
            begin
                // Port, buffer and terminator are re-initialized together
                term_next = term_set_reg[7:0];
                rst_cnt_next = rst_cnt_reg + 2'h1;
                if (rst_cnt_reg == 2'(`FAML_RESET_CYC - 1))
                begin
                    prst_next = 1'b0;
                    state_next = FAML_IDLE;
                end
            end
            default: state_next = FAML_IDLE;
        endcase
        // Abort leaves the line idle; the unsent bits of the character go out as ones, so the far end takes a corrupted byte with a valid stop bit
        if (sending && to_cnt_reg >= limit)
        begin
            tx_status_next = `FAML_ST_TIMEOUT;
            state_next = FAML_IDLE;
        end
        txd_next = (state_next == FAML_SHIFT) ? shift_next[0] : 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= FAML_IDLE;
            tx_status_reg <= `FAML_ST_OK;
            term_reg <= 8'h0D;
            prst_reg <= 1'b0;
            ierr_reg <= 1'b0;
            nstat_reg <= 2'h0;
            instr_prev_reg <= 1'b0;
            word_reg <= 9'h000;
            pend_reg <= 1'b0;
            len_reg <= 10'h000;
            byte_reg <= 10'h000;
            shift_reg <= 10'h3FF;
            bit_reg <= 4'h0;
            baud_cnt_reg <= 16'h0000;
            to_cnt_reg <= 32'h0000_0000;
            rst_cnt_reg <= 2'h0;
            flush_reg <= 1'b0;
            txd_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            tx_status_reg <= tx_status_next;
            term_reg <= term_next;
            prst_reg <= prst_next;
            ierr_reg <= ierr_next;
            nstat_reg <= nstat_next;
            instr_prev_reg <= instr_reg;
            word_reg <= word_next;
            pend_reg <= pend_next;
            len_reg <= len_next;
            byte_reg <= byte_next;
            shift_reg <= shift_next;
            bit_reg <= bit_next;
            baud_cnt_reg <= baud_cnt_next;
            to_cnt_reg <= to_cnt_next;
            rst_cnt_reg <= rst_cnt_next;
            flush_reg <= flush_next;
            txd_reg <= txd_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_char_end;
        state_reg == FAML_SHIFT && bit_reg == 4'h9 && {16'h0000, baud_cnt_reg} == div - 32'h0000_0001;
    endsequence
    sequence s_last_char;
        s_char_end ##0 ((byte_reg + 10'h001 == len_reg) && to_cnt_reg < limit);
    endsequence
    // Flush pulse first, then the flag drops two edges later with the new terminator in place
    sequence s_reset_done;
        rx_flush ##2 (!prst_reg && term_reg == term_set_reg[7:0]);
    endsequence

    a_status_while_sending: assert property (sending |-> tx_status_reg == `FAML_ST_SENDING)
        else $error("status not 0001 during send");
    a_busy_refused: assert property (state_reg == FAML_IDLE && start && is_tx && !tx_bad && !prst_reg
        && line_rx_busy |=> tx_status_reg == `FAML_ST_BUSY && state_reg == FAML_IDLE)
        else $error("busy port did not refuse send");
    a_reset_refused: assert property (state_reg == FAML_IDLE && start && is_tx && !tx_bad && prst_reg
        |=> tx_status_reg == `FAML_ST_RESET)
        else $error("send during reset not reported");
    a_timeout_report: assert property (sending && to_cnt_reg >= limit
        |=> state_reg == FAML_IDLE && tx_status_reg == `FAML_ST_TIMEOUT && txd)
        else $error("send time-out not reported");
    a_no_terminator: assert property (state_reg == FAML_SCAN && !scan_lo && !scan_hi
        && {7'h00, word_reg} >= size_reg |=> tx_status_reg == `FAML_ST_NOTERM && txd)
        else $error("missing terminator not reported");
    a_reset_deferred: assert property (state_reg == FAML_IDLE && prst_reg && line_rx_busy
        |=> state_reg != FAML_RESET)
        else $error("reset started during reception");
    a_reset_sequence: assert property (state_reg == FAML_IDLE && prst_reg && !line_rx_busy
        && !(start && (is_tx || is_rx)) |=> s_reset_done)
        else $error("port reset sequence wrong");
    a_param_error: assert property (state_reg == FAML_IDLE && start && is_tx && tx_bad
        |=> ierr_reg && state_reg == FAML_IDLE)
        else $error("bad size did not set error flag");
    a_stop_after_term: assert property (s_last_char
        |=> (state_reg == FAML_IDLE && tx_status_reg == `FAML_ST_OK) ##1 txd[*2])
        else $error("transmission went past terminator");
    a_start_bit: assert property (state_reg == FAML_LOAD |=> !txd)
        else $error("character without start bit");
endmodule
`default_nettype wire

/* faml_consts.svh */
`ifndef FAML_CONSTS_SVH
`define FAML_CONSTS_SVH

// Clock and timing
`define FAML_CLK_HZ 10000000
`define FAML_TO_SLOW_MS 30000
`define FAML_TO_2400_MS 15000
`define FAML_TO_4800_MS 7000
`define FAML_TO_9600_MS 3000
`define FAML_TO_19200_MS 1500
`define FAML_RESET_CYC 2

// Line rates selected by the rate register
`define FAML_BAUD_300 300
`define FAML_BAUD_600 600
`define FAML_BAUD_1200 1200
`define FAML_BAUD_2400 2400
`define FAML_BAUD_4800 4800
`define FAML_BAUD_9600 9600
`define FAML_BAUD_19200 19200

// Register byte offsets
`define FAML_OFF_CTRL 12'h000
`define FAML_OFF_SRC_TYPE 12'h004
`define FAML_OFF_SRC_ADDR 12'h008
`define FAML_OFF_SIZE 12'h00C
`define FAML_OFF_DST_TYPE 12'h010
`define FAML_OFF_DST_ADDR 12'h014
`define FAML_OFF_TX_STATUS 12'h018
`define FAML_OFF_TERM 12'h01C
`define FAML_OFF_BAUD 12'h020
`define FAML_OFF_FLAGS 12'h024
`define FAML_MEM_BASE_BIT 10

// Field positions
`define FAML_CTRL_INSTR 0
`define FAML_CTRL_PRST 1
`define FAML_FLAGS_OUT 0
`define FAML_FLAGS_IERR 1
`define FAML_FLAGS_BUSY 2
`define FAML_FLAGS_NSTAT_LSB 4
`define FAML_FLAGS_TERM_LSB 8

// Reset values and codes
`define FAML_TERM_RESET 16'h000D
`define FAML_BAUD_RESET 3'h5
`define FAML_TYPE_PORT 8'h30
`define FAML_MAX_WORDS 16'h0100
`define FAML_NSTAT_RX 2'h2
`define FAML_NSTAT_TX 2'h1
`define FAML_ST_OK 16'h0000
`define FAML_ST_SENDING 16'h0001
`define FAML_ST_BUSY 16'h0002
`define FAML_ST_RESET 16'h0003
`define FAML_ST_TIMEOUT 16'h0004
`define FAML_ST_NOTERM 16'h0005

`endif

/* faml_pkg.sv */
package faml_pkg;
    typedef enum logic [2:0] {
        FAML_IDLE = 3'h0,
        FAML_SCAN = 3'h1,
        FAML_FETCH = 3'h3,
        FAML_LOAD = 3'h2,
        FAML_SHIFT = 3'h6,
        FAML_RESET = 3'h4
    } faml_state_type;
endpackage

/* faml_mem_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface faml_mem_if;
    logic we;
    logic [7:0] waddr;
    logic [15:0] wdata;
    logic [7:0] raddr;
    logic [15:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

/* faml_msg_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module faml_msg_mem
#(
    parameter int DEPTH = 256,
    parameter int WIDTH = 16
)
(
    input wire logic pclk,
    faml_mem_if.mem port
);
    logic [WIDTH-1:0] store [DEPTH];

    if (DEPTH != 256 || WIDTH != 16)
    begin : g_size_check
        $error("faml_msg_mem: only 256 x 16 is served by the carrier");
    end

    // No reset on the array: contents are software's to load
    always_ff @(posedge pclk)
    begin
        if (port.we)
        begin
            store[port.waddr] <= port.wdata;
        end
        port.rdata <= store[port.raddr];
    end
endmodule
`default_nettype wire

/* faml_uart_peer.sv */
`timescale 1ns/10ps
`default_nettype none
module faml_uart_peer
#(
    parameter int BIT = 5
)
(
    input wire logic pclk,
    input wire logic txd,
    input wire logic busy_req,
    output logic line_rx_busy
);
    logic [7:0] rx_q[$];
    logic [7:0] sh;
    assign line_rx_busy = busy_req;
    // Mid-bit sampling tolerates the truncated bit count of the sender
    always
    begin
        @(negedge txd);
        repeat (BIT / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT) @(posedge pclk);
            sh[i] = txd;
        end
        repeat (BIT) @(posedge pclk);
        // A frame without its stop bit is dropped, so the byte count exposes it
        if (txd === 1'b1)
            rx_q.push_back(sh);
    end
endmodule
`default_nettype wire

/* tb_free_ascii_message_link.sv */
`timescale 1ns/10ps
`default_nettype none
`include "faml_consts.svh"
module tb_free_ascii_message_link;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, busy_req = 0, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, q, prdata;
    logic pready, pslverr, txd, line_rx_busy, rx_flush, instruction_output, instruction_error_flag;
    logic [7:0] exp_b[3] = '{8'h41, 8'h42, 8'h0D};
    logic [15:0] da[3] = '{16'h0000, 16'h0000, 16'h0001};
    logic [15:0] sz[3] = '{16'h0000, 16'h0101, 16'h0003};
    int fail_count = 0, compares = 0, flush_n = 0;
    always #50 pclk = ~pclk;
    // Short clock figure keeps bit times at a few cycles
    faml_link #(.CLK_HZ(100000)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .txd(txd), .line_rx_busy(line_rx_busy), .rx_flush(rx_flush), .instruction_output(instruction_output),
        .instruction_error_flag(instruction_error_flag));
    faml_uart_peer #(.BIT(5)) i_peer (.pclk(pclk), .txd(txd), .busy_req(busy_req), .line_rx_busy(line_rx_busy));
    always @(posedge pclk) if (rx_flush === 1'b1) flush_n++;
    ////////////////////////////////////////////////////////////////
    task summarize;
        $display("fail_count=%0d compares=%0d", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
        if (n >= 50) begin fail_count++; summarize(); end
    endtask
    task start(input logic [15:0] s);
        apb(1, `FAML_OFF_SIZE, {16'h0, s});
        apb(1, `FAML_OFF_CTRL, 32'h0);
        apb(1, `FAML_OFF_CTRL, 32'h1);
        // The engine acts on the edge that ends this write; let its outputs settle first
        @(posedge pclk);
    endtask
    // Polls until the selected bits leave the given value, bounded
    task wait_while(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        apb(0, a, 32'h0);
        while ((q & m) === v && n < 2000) begin apb(0, a, 32'h0); n++; end
        if (n >= 2000) begin fail_count++; summarize(); end
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, `FAML_OFF_TERM, 0); chk(q, 32'h0D);
        apb(0, `FAML_OFF_TX_STATUS, 0); chk(q, 32'h0);
        apb(0, `FAML_OFF_FLAGS, 0); chk(q & 32'hFF00, 32'h0D00);
        apb(0, 12'h3FC, 0); chk({31'h0, e}, 32'h1);
        $display("test reset values done");
        apb(1, `FAML_OFF_BAUD, 32'h6);
        apb(1, 12'h400, 32'h4241);
        apb(1, 12'h404, 32'h440D);
        apb(1, 12'h408, 32'h4545);
        apb(1, `FAML_OFF_DST_TYPE, 32'h30);
        start(3);
        apb(0, `FAML_OFF_TX_STATUS, 0); chk(q, 32'h1);
        chk({31'h0, instruction_output}, 32'h1);
        wait_while(`FAML_OFF_TX_STATUS, 32'hFFFF, 32'h1); chk(q, 32'h0);
        chk(i_peer.rx_q.size(), 3);
        for (int i = 0; i < 3; i++) chk(i_peer.rx_q[i], exp_b[i]);
        apb(0, `FAML_OFF_FLAGS, 0); chk(q & 32'h37, 32'h11);
        $display("test send done");
        busy_req <= 1;
        apb(1, `FAML_OFF_TERM, 32'h0003);
        start(3); apb(0, `FAML_OFF_TX_STATUS, 0); chk(q, 32'h2);
        apb(1, `FAML_OFF_CTRL, 32'h3);
        repeat (10) @(posedge pclk);
        apb(0, `FAML_OFF_CTRL, 0); chk(q & 32'h2, 32'h2);
        chk(flush_n, 0);
        busy_req <= 0;
        wait_while(`FAML_OFF_CTRL, 32'h2, 32'h2);
        chk(flush_n, 1);
        apb(0, `FAML_OFF_FLAGS, 0); chk(q & 32'hFF00, 32'h0300);
        $display("test busy and port reset done");
        apb(1, `FAML_OFF_CTRL, 32'h0);
        apb(1, `FAML_OFF_CTRL, 32'h3);
        apb(0, `FAML_OFF_TX_STATUS, 0); chk(q, 32'h3);
        wait_while(`FAML_OFF_CTRL, 32'h2, 32'h2);
        start(2);
        wait_while(`FAML_OFF_TX_STATUS, 32'hFFFF, 32'h1); chk(q, 32'h5);
        chk(i_peer.rx_q.size(), 3);
        $display("test status codes done");
        for (int i = 0; i < 3; i++)
        begin
            apb(1, `FAML_OFF_FLAGS, 32'h2); chk({31'h0, instruction_error_flag}, 32'h0);
            apb(1, `FAML_OFF_DST_ADDR, {16'h0, da[i]});
            start(sz[i]); chk({31'h0, instruction_error_flag}, 32'h1);
            apb(0, `FAML_OFF_TX_STATUS, 0); chk(q, 32'h5);
        end
        apb(1, `FAML_OFF_DST_TYPE, 32'h0);
        apb(1, `FAML_OFF_SRC_TYPE, 32'h30);
        apb(1, `FAML_OFF_FLAGS, 32'h2);
        start(255); chk({31'h0, instruction_error_flag}, 32'h1);
        apb(1, `FAML_OFF_FLAGS, 32'h2);
        start(256); chk({31'h0, instruction_error_flag}, 32'h0);
        apb(0, `FAML_OFF_FLAGS, 0); chk(q & 32'h30, 32'h20);
        $display("test parameter errors done");
        summarize();
    end
endmodule
`default_nettype wire
